/* logic/watchdog_pkg.sv */
// Constants for the watchdog overflow handling block.
// Assumes a single 50 MHz clock; one timer state equals one clock cycle.
// Overview of operation
// - Watchdog overflow with reset disabled: no chip reset.
// - That overflow still reinitialises counter and control.
// - Writes ignored while overflow output is low.
// - Flag reads while output low do not arm.
// - Set coinciding with read leaves read unarmed.
// - Counter wrap in watchdog mode sets flag.
// - Word writes only, upper byte key selects target.
// - Key plus zero clears only the watchdog flag.
// - Overflow output held 132 or 130 states.
package watchdog_pkg;
    // ******************************
    // Write keys and data patterns
    // ******************************
    localparam logic [7:0] KEY_COUNTER    = 8'h5A;
    localparam logic [7:0] KEY_CONTROL    = 8'hA5;
    localparam logic [7:0] KEY_FLAG_CLEAR = 8'hA5;
    localparam logic [7:0] KEY_RESET_BITS = 8'h5A;
    localparam logic [7:0] CLEAR_DATA     = 8'h00;
    localparam logic [7:0] COUNT_MAX      = 8'hFF;
    localparam logic [7:0] COUNT_RESET    = 8'h00;

    // ******************************
    // Field positions
    // ******************************
    localparam int TCS_IV_FLAG_BIT  = 7;
    localparam int TCS_MODE_BIT     = 6;
    localparam int TCS_RUN_BIT      = 5;
    localparam int TCS_CLK_SEL_LSB  = 0;
    localparam int TCS_CLK_SEL_MSB  = 2;
    localparam int RCS_WD_FLAG_BIT  = 7;
    localparam int RCS_RST_EN_BIT   = 6;
    localparam int RCS_RST_TYPE_BIT = 5;
    localparam logic [7:0] TCS_RESERVED_ONES = 8'h18;
    localparam logic [7:0] RCS_RESERVED_ONES = 8'h1F;

    // ******************************
    // Read selects
    // ******************************
    localparam logic [1:0] RD_CONTROL = 2'h0;
    localparam logic [1:0] RD_COUNTER = 2'h1;
    localparam logic [1:0] RD_RESET   = 2'h2;

    // ******************************
    // Pulse lengths in states
    // ******************************
    localparam int HOLD_W = 10;
    localparam logic [HOLD_W-1:0] HOLD_RESET_ON  = 10'h084;
    localparam logic [HOLD_W-1:0] HOLD_RESET_OFF = 10'h082;
    localparam logic [HOLD_W-1:0] HOLD_CHIP_RST  = 10'h206;
endpackage : watchdog_pkg

/* logic/hold_timer.sv */
// Retriggerable pulse stretcher: idle_q low for load_value cycles.
// Assumes load is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module hold_timer #(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              idle_q
);
    logic [W-1:0] count_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            idle_q  <= 1'b1;
        end else if (load) begin
            count_q <= load_value;
            idle_q  <= 1'b0;
        end else if (count_q != '0) begin
            count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
            idle_q  <= (count_q == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule : hold_timer

/* logic/watchdog_unit.sv */
// Watchdog/interval timer with overflow output, write lockout and flag clearing.
// Assumes count_tick and all access ports come from logic on clk.
`timescale 1ns/1ps
module watchdog_unit (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       count_tick,
    input  wire logic       wr_en,
    input  wire logic       wr_word,
    input  wire logic       wr_reset_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic       rd_en,
    input  wire logic [1:0] rd_sel,
    output logic [7:0]      rd_data_q,
    output logic            overflow_output_n,
    output logic            chip_reset_n,
    output logic            reset_type_select_q,
    output logic            interval_irq_q,
    output logic [2:0]      clock_select_q
);
    import watchdog_pkg::*;

    // ******************************
    // State
    // ******************************
    logic [7:0] watchdog_counter_q;
    logic       interval_overflow_flag_q;
    logic       watchdog_mode_q;
    logic       timer_run_q;
    logic       watchdog_overflow_flag_q;
    logic       reset_enable_bit_q;
    logic       wd_flag_armed_q;
    logic       iv_flag_armed_q;

    // ******************************
    // Decode
    // ******************************
    logic       locked;
    logic       wr_ok;
    logic       wr_counter;
    logic       wr_control;
    logic       wr_flag_clear;
    logic       wr_reset_bits;
    logic       wrap;
    logic       wd_overflow;
    logic       iv_overflow;
    logic       rd_control;
    logic       rd_reset;

    assign locked        = !overflow_output_n;
    assign wr_ok         = wr_en && wr_word && !locked;
    assign wr_counter    = wr_ok && !wr_reset_addr && (wr_data[15:8] == KEY_COUNTER);
    assign wr_control    = wr_ok && !wr_reset_addr && (wr_data[15:8] == KEY_CONTROL);
    assign wr_flag_clear = wr_ok && wr_reset_addr && (wr_data[15:8] == KEY_FLAG_CLEAR)
                           && (wr_data[7:0] == CLEAR_DATA);
    assign wr_reset_bits = wr_ok && wr_reset_addr && (wr_data[15:8] == KEY_RESET_BITS);
    // Counter write beats a coinciding increment
    assign wrap          = timer_run_q && count_tick && !wr_counter && (watchdog_counter_q == COUNT_MAX);
    assign wd_overflow   = wrap && watchdog_mode_q;
    assign iv_overflow   = wrap && !watchdog_mode_q;
    assign rd_control    = rd_en && (rd_sel == RD_CONTROL);
    assign rd_reset      = rd_en && (rd_sel == RD_RESET);

    // ******************************
    // Counter
    // ******************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_counter_q <= COUNT_RESET;
        end else if (wd_overflow) begin
            watchdog_counter_q <= COUNT_RESET;
        end else if (wr_counter) begin
            watchdog_counter_q <= wr_data[7:0];
        end else if (timer_run_q && count_tick) begin
            watchdog_counter_q <= watchdog_counter_q + 8'h01;
        end
    end

    // ******************************
    // Timer control and status
    // ******************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_mode_q <= 1'b0;
            timer_run_q     <= 1'b0;
            clock_select_q  <= 3'h0;
        end else if (wd_overflow) begin
            // Watchdog overflow returns control to reset values either way
            watchdog_mode_q <= 1'b0;
            timer_run_q     <= 1'b0;
            clock_select_q  <= 3'h0;
        end else if (wr_control) begin
            watchdog_mode_q <= wr_data[TCS_MODE_BIT];
            timer_run_q     <= wr_data[TCS_RUN_BIT];
            clock_select_q  <= wr_data[TCS_CLK_SEL_MSB:TCS_CLK_SEL_LSB];
        end
    end

    // Interval flag: a set wins over a clearing write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interval_overflow_flag_q <= 1'b0;
            iv_flag_armed_q          <= 1'b0;
        end else if (iv_overflow) begin
            interval_overflow_flag_q <= 1'b1;
            // Read racing the set does not arm the clear
            iv_flag_armed_q          <= iv_flag_armed_q && !rd_control;
        end else if (wd_overflow) begin
            interval_overflow_flag_q <= 1'b0;
            iv_flag_armed_q          <= 1'b0;
        end else if (wr_control && !wr_data[TCS_IV_FLAG_BIT] && iv_flag_armed_q) begin
            interval_overflow_flag_q <= 1'b0;
            iv_flag_armed_q          <= 1'b0;
        end else if (rd_control && interval_overflow_flag_q && !locked) begin
            iv_flag_armed_q          <= 1'b1;
        end
    end

    assign interval_irq_q = interval_overflow_flag_q;

    // ******************************
    // Reset control and status
    // ******************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_overflow_flag_q <= 1'b0;
            wd_flag_armed_q          <= 1'b0;
        end else if (wd_overflow) begin
            watchdog_overflow_flag_q <= 1'b1;
            wd_flag_armed_q          <= 1'b0;
        end else if (wr_flag_clear && wd_flag_armed_q) begin
            watchdog_overflow_flag_q <= 1'b0;
            wd_flag_armed_q          <= 1'b0;
        end else if (rd_reset && watchdog_overflow_flag_q && !locked) begin
            wd_flag_armed_q          <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_enable_bit_q  <= 1'b0;
            reset_type_select_q <= 1'b0;
        end else if (wr_reset_bits) begin
            reset_enable_bit_q  <= wr_data[RCS_RST_EN_BIT];
            reset_type_select_q <= wr_data[RCS_RST_TYPE_BIT];
        end
    end

    // ******************************
    // Overflow output and internal reset
    // ******************************
    hold_timer #(.W(HOLD_W)) u_out_hold (
        .clk        (clk),
        .arst_n     (arst_n),
        .load       (wd_overflow),
        .load_value (reset_enable_bit_q ? HOLD_RESET_ON : HOLD_RESET_OFF),
        .idle_q     (overflow_output_n)
    );

    // Chip reset only when enabled; stays high otherwise
    hold_timer #(.W(HOLD_W)) u_chip_hold (
        .clk        (clk),
        .arst_n     (arst_n),
        .load       (wd_overflow && reset_enable_bit_q),
        .load_value (HOLD_CHIP_RST),
        .idle_q     (chip_reset_n)
    );

    // ******************************
    // Read data
    // ******************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            unique case (rd_sel)
                RD_CONTROL: rd_data_q <= {interval_overflow_flag_q, watchdog_mode_q, timer_run_q, 5'h00}
                                         | TCS_RESERVED_ONES | {5'h00, clock_select_q};
                RD_COUNTER: rd_data_q <= watchdog_counter_q;
                RD_RESET:   rd_data_q <= {watchdog_overflow_flag_q, reset_enable_bit_q,
                                          reset_type_select_q, 5'h00} | RCS_RESERVED_ONES;
                default:    rd_data_q <= 8'h00;
            endcase
        end
    end

    // ******************************
    // Assertions
    // ******************************
    a_no_chip_reset: assert property (@(posedge clk) disable iff (!arst_n)
        wd_overflow && !reset_enable_bit_q |=> chip_reset_n [*3])
        else $error("chip reset issued with reset disabled");

    a_reinit_state: assert property (@(posedge clk) disable iff (!arst_n)
        wd_overflow |=> watchdog_counter_q == COUNT_RESET && !timer_run_q && !watchdog_mode_q)
        else $error("counter or control not reinitialised");

    a_lock_writes: assert property (@(posedge clk) disable iff (!arst_n)
        !overflow_output_n && !wd_overflow |=> $stable(reset_enable_bit_q) && $stable(reset_type_select_q)
        && $stable(timer_run_q) && $stable(clock_select_q)
        && $stable(watchdog_counter_q) && $stable(watchdog_mode_q))
        else $error("write accepted during lockout");

    a_no_arm_locked: assert property (@(posedge clk) disable iff (!arst_n)
        !overflow_output_n |-> !wd_flag_armed_q)
        else $error("flag read armed during lockout");

    a_race_unarmed: assert property (@(posedge clk) disable iff (!arst_n)
        iv_overflow && rd_control |=> !iv_flag_armed_q ##0 interval_overflow_flag_q)
        else $error("racing read armed the clear");

    a_wd_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
        wd_overflow |=> watchdog_overflow_flag_q && !overflow_output_n)
        else $error("watchdog flag not set on wrap");

    a_flag_clear: assert property (@(posedge clk) disable iff (!arst_n)
        wr_flag_clear && wd_flag_armed_q && !wd_overflow
        |=> !watchdog_overflow_flag_q && $stable(reset_enable_bit_q) && $stable(reset_type_select_q))
        else $error("flag clear write misbehaved");

    a_hold_long: assert property (@(posedge clk) disable iff (!arst_n)
        wd_overflow && reset_enable_bit_q |=> !overflow_output_n ##131 !overflow_output_n ##1 overflow_output_n)
        else $error("overflow output length wrong with reset enabled");

    a_hold_short: assert property (@(posedge clk) disable iff (!arst_n)
        wd_overflow && !reset_enable_bit_q |=> !overflow_output_n ##129 !overflow_output_n ##1 overflow_output_n)
        else $error("overflow output length wrong with reset disabled");
endmodule : watchdog_unit

/* tb/reset_circuit_model.sv */
// Model of the system reset circuit that the watchdog drives.
// Assumes both inputs are registered outputs on clk.
`timescale 1ns/1ps
module reset_circuit_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       out_n,
    input  wire logic       rst_n,
    output logic [9:0]      out_len_q,
    output logic [9:0]      rst_len_q
);
    // ******************************
    // Low-pulse length capture
    // ******************************
    logic [9:0] out_cnt_q;
    logic [9:0] rst_cnt_q;
    // Counts sampled low edges; the length is latched on release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_cnt_q <= 10'h000;
            rst_cnt_q <= 10'h000;
            out_len_q <= 10'h000;
            rst_len_q <= 10'h000;
        end else begin
            out_cnt_q <= out_n ? 10'h000 : out_cnt_q + 10'h001;
            rst_cnt_q <= rst_n ? 10'h000 : rst_cnt_q + 10'h001;
            if (out_n && out_cnt_q != 10'h000) out_len_q <= out_cnt_q;
            if (rst_n && rst_cnt_q != 10'h000) rst_len_q <= rst_cnt_q;
        end
    end
endmodule : reset_circuit_model

/* tb/watchdog_unit_tb.sv */
// Self-checking bench for the watchdog overflow handling block.
// Assumes the package constants and the reset circuit model.
`timescale 1ns/1ps
module watchdog_unit_tb;
    import watchdog_pkg::*;
    // ******************************
    // Stimulus and results
    // ******************************
    typedef struct packed {logic a; logic w; logic [15:0] d; logic [1:0] s; logic [7:0] e;} row_s;
    row_s rows [8] = '{
        '{1'b0, 1'b1, 16'h5A10, 2'h1, 8'h10},
        '{1'b0, 1'b0, 16'h5A33, 2'h1, 8'h10},
        '{1'b0, 1'b1, 16'h3C33, 2'h1, 8'h10},
        '{1'b0, 1'b1, 16'hA525, 2'h0, 8'h3D},
        '{1'b1, 1'b1, 16'h5A60, 2'h2, 8'h7F},
        '{1'b1, 1'b1, 16'h5A00, 2'h2, 8'h1F},
        '{1'b1, 1'b1, 16'hA500, 2'h2, 8'h1F},
        '{1'b0, 1'b0, 16'h0000, 2'h3, 8'h00}
    };
    logic clk = 1'b0, arst_n = 1'b0, count_tick = 1'b0, wr_en = 1'b0, wr_word = 1'b0;
    logic wr_reset_addr = 1'b0, rd_en = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic [1:0]  rd_sel = 2'h0;
    logic [7:0]  rd_data_q;
    logic [2:0]  clock_select_q;
    logic        overflow_output_n, chip_reset_n, reset_type_select_q, interval_irq_q;
    logic [9:0]  out_len, rst_len;
    int          miscompares = 0;
    int          checks_done = 0;

    watchdog_unit DUT (.clk(clk), .arst_n(arst_n), .count_tick(count_tick), .wr_en(wr_en), .wr_word(wr_word),
        .wr_reset_addr(wr_reset_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_sel(rd_sel), .rd_data_q(rd_data_q),
        .overflow_output_n(overflow_output_n), .chip_reset_n(chip_reset_n),
        .reset_type_select_q(reset_type_select_q), .interval_irq_q(interval_irq_q),
        .clock_select_q(clock_select_q));
    reset_circuit_model partner (.clk(clk), .arst_n(arst_n), .out_n(overflow_output_n), .rst_n(chip_reset_n),
        .out_len_q(out_len), .rst_len_q(rst_len));

    always #10 clk = ~clk;

    // ******************************
    // Tasks
    // ******************************
    task end_of_test;
        $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task chk_val(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task chk_bit(input logic got, input logic exp);
        chk_val({9'h000, got}, {9'h000, exp});
    endtask : chk_bit
    task step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : step
    task wr(input logic a, input logic w, input logic [15:0] d);
        wr_reset_addr = a;
        wr_word = w;
        wr_data = d;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
        // Idle edge so a following strobe is never re-raised in this step
        step(1);
    endtask : wr
    // Read strobe optionally shares its edge with a count pulse
    task rd_chk(input logic [1:0] s, input logic [7:0] e, input logic t = 1'b0, input logic c = 1'b1);
        rd_sel = s;
        rd_en = 1'b1;
        count_tick = t;
        step(1);
        rd_en = 1'b0;
        count_tick = 1'b0;
        if (c) chk_val({2'h0, rd_data_q}, {2'h0, e});
        step(1);
    endtask : rd_chk
    task tick;
        count_tick = 1'b1;
        step(1);
        count_tick = 1'b0;
        step(1);
    endtask : tick
    task wait_ovf(input logic lvl);
        int i;
        for (i = 0; i < 600 && overflow_output_n !== lvl; i++) step(1);
        if (i == 600) begin
            miscompares++;
            $display("Error at %0t: overflow output wait timed out", $time);
            end_of_test;
        end
    endtask : wait_ovf

    // ******************************
    // Main sequence
    // ******************************
    initial begin
        step(2);
        arst_n = 1'b1;
        chk_bit(overflow_output_n, 1'b1);
        chk_bit(chip_reset_n, 1'b1);
        rd_chk(RD_CONTROL, TCS_RESERVED_ONES);
        rd_chk(RD_RESET, RCS_RESERVED_ONES);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w, rows[k].d);
            rd_chk(rows[k].s, rows[k].e);
        end
        chk_val({7'h00, clock_select_q}, 10'h005);
        // Interval mode: plain set and clear, then a set racing a read
        wr(1'b0, 1'b1, 16'h5AFF);
        tick;
        chk_bit(interval_irq_q, 1'b1);
        rd_chk(RD_COUNTER, 8'h00);
        rd_chk(RD_CONTROL, 8'hBD);
        wr(1'b0, 1'b1, 16'hA525);
        chk_bit(interval_irq_q, 1'b0);
        wr(1'b0, 1'b1, 16'h5AFF);
        rd_chk(RD_CONTROL, 8'h3D, 1'b1, 1'b1);
        wr(1'b0, 1'b1, 16'hA525);
        chk_bit(interval_irq_q, 1'b1);
        rd_chk(RD_CONTROL, 8'hBD);
        rd_chk(RD_CONTROL, 8'hBD);
        wr(1'b0, 1'b1, 16'hA525);
        chk_bit(interval_irq_q, 1'b0);
        // Watchdog overflow with internal reset disabled
        wr(1'b1, 1'b1, 16'h5A00);
        wr(1'b0, 1'b1, 16'hA560);
        wr(1'b0, 1'b1, 16'h5AFF);
        tick;
        wait_ovf(1'b0);
        chk_bit(chip_reset_n, 1'b1);
        wr(1'b0, 1'b1, 16'h5A44);
        wr(1'b0, 1'b1, 16'hA560);
        wr(1'b1, 1'b1, 16'h5A60);
        rd_chk(RD_RESET, 8'h9F);
        rd_chk(RD_COUNTER, 8'h00);
        rd_chk(RD_CONTROL, 8'h18);
        chk_val({7'h00, clock_select_q}, 10'h000);
        wait_ovf(1'b1);
        wr(1'b0, 1'b1, 16'h5A22);
        rd_chk(RD_COUNTER, 8'h22);
        chk_val(out_len, 10'h082);
        chk_bit(chip_reset_n, 1'b1);
        wr(1'b1, 1'b1, 16'hA500);
        rd_chk(RD_RESET, 8'h9F);
        rd_chk(RD_RESET, 8'h9F);
        wr(1'b1, 1'b1, 16'hA500);
        rd_chk(RD_RESET, 8'h1F);
        // Watchdog overflow with internal reset enabled
        wr(1'b1, 1'b1, 16'h5A60);
        wr(1'b0, 1'b1, 16'hA560);
        wr(1'b0, 1'b1, 16'h5AFF);
        tick;
        wait_ovf(1'b0);
        chk_bit(chip_reset_n, 1'b0);
        chk_bit(reset_type_select_q, 1'b1);
        wait_ovf(1'b1);
        step(400);
        chk_val(out_len, 10'h084);
        chk_val(rst_len, 10'h206);
        rd_chk(RD_RESET, 8'hFF);
        wr(1'b1, 1'b1, 16'hA500);
        rd_chk(RD_RESET, 8'h7F);
        // Mid-run reset returns every register to its reset value
        arst_n = 1'b0;
        step(1);
        chk_val({2'h0, rd_data_q}, 10'h000);
        chk_bit(reset_type_select_q, 1'b0);
        arst_n = 1'b1;
        rd_chk(RD_RESET, RCS_RESERVED_ONES);
        end_of_test;
    end
endmodule : watchdog_unit_tb
